/* scwd_defines.svh */
`ifndef SCWD_DEFINES_SVH
`define SCWD_DEFINES_SVH

// control word bit positions
`define SCWD_BIT_PRESET_LO    0
`define SCWD_BIT_PRESET_HI    1
`define SCWD_BIT_RSVD2        2
`define SCWD_BIT_NO_COAST     3
`define SCWD_BIT_NO_QSTOP     4
`define SCWD_BIT_NO_HOLD      5
`define SCWD_BIT_START        6
`define SCWD_BIT_FAULT_ACK    7
`define SCWD_BIT_JOG          8
`define SCWD_BIT_RAMP_SEL     9
`define SCWD_BIT_DATA_VALID   10

// register offsets
`define SCWD_OFS_PROFILE      16'h0001
`define SCWD_OFS_CTRL_WORD    16'h0002

// reset values
`define SCWD_RST_CTRL_WORD    16'h0000
`define SCWD_RST_PROFILE      16'h0000

// response time
`define SCWD_RESP_TIME_NS     5000000
`define SCWD_CLK_PERIOD_NS    8
`define SCWD_RESP_CYCLES      (`SCWD_RESP_TIME_NS / `SCWD_CLK_PERIOD_NS)

`endif

/* scwd_pkg.sv */
package scwd_pkg;

    typedef enum logic [1:0] {
        SCWD_OBJ_COIL    = 2'h0,
        SCWD_OBJ_INPUT   = 2'h1,
        SCWD_OBJ_HOLDING = 2'h2
    } scwd_obj_t;

    typedef struct packed {
        logic             valid;
        logic             write;
        scwd_obj_t        obj;
        logic [15:0]      addr;
        logic [15:0]      wdata;
    } scwd_req_t;

    typedef struct packed {
        logic             valid;
        logic             error;
        logic [15:0]      rdata;
    } scwd_rsp_t;

    typedef struct packed {
        logic [1:0]       preset_sel;
        logic             coast;
        logic             quick_stop;
        logic             hold;
        logic             run_enable;
        logic             ramp_stop;
        logic             jog;
        logic             ramp2_sel;
    } scwd_cmd_t;

endpackage

/* scwd_fault_ack.sv */
`timescale 1ns/1ns
`default_nettype none
`include "scwd_defines.svh"

module scwd_fault_ack (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // control word update
    input  wire logic ctrl_update,
    input  wire logic ack_bit,
    // fault gating
    input  wire logic fault_cond_clear,
    input  wire logic other_acks_done,
    // result
    output logic      fault_ack_pulse
);

    logic ack_prev_reg;

    // bit 7 value from previous control word update
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_prev_reg <= 1'b0;
        end else if (ctrl_update) begin
            ack_prev_reg <= ack_bit;
        end
    end

    // rising edge only, gated by fault state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_ack_pulse <= 1'b0;
        end else begin
            fault_ack_pulse <= ctrl_update && ack_bit && !ack_prev_reg
                               && fault_cond_clear && other_acks_done;
        end
    end

endmodule // scwd_fault_ack
`default_nettype wire

/* scwd_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
`include "scwd_defines.svh"

module scwd_decoder #(
    parameter int RESP_CYCLES = `SCWD_RESP_CYCLES
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // modbus object request and answer
    input  wire scwd_pkg::scwd_req_t req,
    output scwd_pkg::scwd_rsp_t      rsp,
    // drive state inputs
    input  wire logic [15:0]        drive_status_word,
    input  wire logic               fault_cond_clear,
    input  wire logic               other_acks_done,
    // command outputs
    output scwd_pkg::scwd_cmd_t      cmd,
    output logic                    fault_ack_pulse,
    output logic [15:0]             drive_control_word,
    output logic [15:0]             fieldbus_profile_select
);

    logic [15:0] ctrl_word_reg;
    logic [15:0] applied_word_reg;
    logic [15:0] profile_reg;
    logic        ctrl_wr;
    logic        prof_wr;
    logic        apply_now;

    function automatic logic hit(input scwd_pkg::scwd_req_t r,
                                 input scwd_pkg::scwd_obj_t o,
                                 input logic [15:0] a);
        hit = r.valid && (r.obj == o) && (r.addr == a);
    endfunction

    // word writes are holding registers, single bits are coils
    assign ctrl_wr = req.valid && req.write &&
                     (hit(req, scwd_pkg::SCWD_OBJ_HOLDING, `SCWD_OFS_CTRL_WORD) ||
                      hit(req, scwd_pkg::SCWD_OBJ_COIL, req.addr));
    assign prof_wr = req.write &&
                     hit(req, scwd_pkg::SCWD_OBJ_HOLDING, `SCWD_OFS_PROFILE);

    // coils address control word bits 0..15
    function automatic logic [15:0] merge(input scwd_pkg::scwd_req_t r,
                                          input logic [15:0] cur);
        logic [15:0] m;
        m = cur;
        if (r.obj == scwd_pkg::SCWD_OBJ_COIL) begin
            m[r.addr[3:0]] = r.wdata[0];
        end else begin
            m = r.wdata;
        end
        merge = m;
    endfunction

    // control word capture
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_word_reg <= `SCWD_RST_CTRL_WORD;
        end else if (ctrl_wr && (req.obj != scwd_pkg::SCWD_OBJ_COIL || req.addr[15:4] == 12'h000)) begin
            ctrl_word_reg <= merge(req, ctrl_word_reg);
        end
    end

    // profile selection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            profile_reg <= `SCWD_RST_PROFILE;
        end else if (prof_wr) begin
            profile_reg <= req.wdata;
        end
    end

    // data valid gate
    assign apply_now = ctrl_word_reg[`SCWD_BIT_DATA_VALID];
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            applied_word_reg <= `SCWD_RST_CTRL_WORD;
        end else if (apply_now) begin
            applied_word_reg <= ctrl_word_reg;
        end
    end

    // level decode, no state machine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd <= '0;
        end else begin
            cmd.preset_sel <= applied_word_reg[`SCWD_BIT_PRESET_HI:`SCWD_BIT_PRESET_LO];
            cmd.coast      <= !applied_word_reg[`SCWD_BIT_NO_COAST];
            cmd.quick_stop <= !applied_word_reg[`SCWD_BIT_NO_QSTOP];
            cmd.hold       <= !applied_word_reg[`SCWD_BIT_NO_HOLD];
            cmd.run_enable <= applied_word_reg[`SCWD_BIT_START];
            cmd.ramp_stop  <= !applied_word_reg[`SCWD_BIT_START];
            cmd.jog        <= applied_word_reg[`SCWD_BIT_JOG];
            cmd.ramp2_sel  <= applied_word_reg[`SCWD_BIT_RAMP_SEL];
        end
    end

    // fault acknowledge edge
    scwd_fault_ack u_fault_ack (
        .clk              (clk),
        .rst_b            (rst_b),
        .ctrl_update      (apply_now),
        .ack_bit          (ctrl_word_reg[`SCWD_BIT_FAULT_ACK]),
        .fault_cond_clear (fault_cond_clear),
        .other_acks_done  (other_acks_done),
        .fault_ack_pulse  (fault_ack_pulse)
    );

    // read data select
    function automatic logic [15:0] rd_sel(input scwd_pkg::scwd_req_t r,
                                           input logic [15:0] cw,
                                           input logic [15:0] pf,
                                           input logic [15:0] sw);
        logic [15:0] d;
        d = 16'h0000;
        unique case (r.obj)
            scwd_pkg::SCWD_OBJ_COIL: begin
                d = {15'h0000, cw[r.addr[3:0]]};
            end
            scwd_pkg::SCWD_OBJ_INPUT: begin
                d = sw;
            end
            scwd_pkg::SCWD_OBJ_HOLDING: begin
                d = (r.addr == `SCWD_OFS_PROFILE) ? pf : cw;
            end
            default: begin
                d = 16'h0000;
            end
        endcase
        rd_sel = d;
    endfunction

    function automatic logic bad(input scwd_pkg::scwd_req_t r);
        logic e;
        e = 1'b0;
        unique case (r.obj)
            scwd_pkg::SCWD_OBJ_COIL: begin
                e = (r.addr[15:4] != 12'h000);
            end
            scwd_pkg::SCWD_OBJ_INPUT: begin
                e = r.write || (r.addr != 16'h0000);
            end
            scwd_pkg::SCWD_OBJ_HOLDING: begin
                e = (r.addr != `SCWD_OFS_PROFILE) && (r.addr != `SCWD_OFS_CTRL_WORD);
            end
            default: begin
                e = 1'b1;
            end
        endcase
        bad = e;
    endfunction

    // one answer per request, next cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.error <= req.valid && bad(req);
            rsp.rdata <= (req.valid && !req.write) ?
                         rd_sel(req, ctrl_word_reg, profile_reg, drive_status_word) : 16'h0000;
        end
    end

    assign drive_control_word      = ctrl_word_reg;
    assign fieldbus_profile_select = profile_reg;

endmodule // scwd_decoder
`default_nettype wire

/* scwd_client.sv */
`timescale 1ns/1ns
`default_nettype none
module scwd_client (
    // clock and answer
    input  wire logic                clk,
    input  wire scwd_pkg::scwd_rsp_t rsp,
    // request
    output var scwd_pkg::scwd_req_t  req
);
    initial req = '0;
    // one pulse a request, released valid, write, address and data inverted, object kept, bounded wait
    task automatic xfer(input logic w, input scwd_pkg::scwd_obj_t o,
            input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e, output logic ok);
        ok = 0;
        @(posedge clk) req <= '{1'b1, w, o, a, d};
        @(posedge clk) req <= '{1'b0, ~w, o, ~a, ~d};
        repeat (4) if (!ok) begin
            #1;
            if (rsp.valid === 1'b1) begin
                ok = 1;
                q = rsp.rdata;
                e = rsp.error;
            end else @(posedge clk);
        end
        @(posedge clk);
    endtask
endmodule // scwd_client
`default_nettype wire

/* scwd_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module scwd_checker (
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // watched ports
    input wire scwd_pkg::scwd_req_t req,
    input wire scwd_pkg::scwd_rsp_t rsp,
    input wire logic                fault_cond_clear,
    input wire scwd_pkg::scwd_cmd_t cmd,
    input wire logic                fault_ack_pulse,
    input wire logic [15:0]         drive_control_word,
    input wire logic [15:0]         fieldbus_profile_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [15:0] w = drive_control_word;
    logic [3:0] coil_reg;
    logic       bit_reg;
    always_ff @(posedge clk) begin
        coil_reg <= req.addr[3:0];
        bit_reg  <= req.wdata[0];
    end
    sequence wr(scwd_pkg::scwd_obj_t o);
        req.valid && req.write && req.obj == o;
    endsequence
    sequence applied;
        w[10] ##1 $stable(w) [*2];
    endsequence
    resp_valid_a: assert property (req.valid |=> rsp.valid) else $error("no answer");
    ctrl_write_a: assert property (wr(scwd_pkg::SCWD_OBJ_HOLDING) ##0 req.addr == 16'h0002
        |=> w == $past(req.wdata) && !rsp.error) else $error("word write");
    profile_write_a: assert property (wr(scwd_pkg::SCWD_OBJ_HOLDING) ##0 req.addr == 16'h0001
        |=> fieldbus_profile_select == $past(req.wdata)) else $error("profile");
    input_ro_a: assert property (wr(scwd_pkg::SCWD_OBJ_INPUT) |=> rsp.error && $stable(w)
        && $stable(fieldbus_profile_select)) else $error("input write");
    coil_write_a: assert property (wr(scwd_pkg::SCWD_OBJ_COIL) ##0 req.addr < 16'h0010
        |=> w[coil_reg] == bit_reg) else $error("coil write");
    cmd_preset_a: assert property (applied |-> cmd.preset_sel == w[1:0])
        else $error("preset");
    cmd_stops_a: assert property (applied |-> cmd.coast == !w[3] && cmd.quick_stop == !w[4]
        && cmd.hold == !w[5]) else $error("stops");
    cmd_run_a: assert property (applied |-> cmd.run_enable == w[6] && cmd.ramp_stop == !w[6])
        else $error("run");
    cmd_jog_ramp_a: assert property (applied |-> cmd.jog == w[8] && cmd.ramp2_sel == w[9])
        else $error("jog ramp");
    ack_pulse_a: assert property (fault_ack_pulse |=> !fault_ack_pulse)
        else $error("long pulse");
    ack_steady_a: assert property ($stable(w) [*4] |-> !fault_ack_pulse)
        else $error("steady ack");
    ack_gate_a: assert property (!fault_cond_clear [*4] |-> !fault_ack_pulse)
        else $error("gated ack");
endmodule // scwd_checker
bind scwd_decoder scwd_checker chk (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp),
    .fault_cond_clear(fault_cond_clear), .cmd(cmd), .fault_ack_pulse(fault_ack_pulse),
    .drive_control_word(drive_control_word),
    .fieldbus_profile_select(fieldbus_profile_select));
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, s) begin n_compared++; if ((s) !== (x)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", n, x, s); end end
module testbench;
    logic                clk = 0;
    logic                rst_b = 0;
    logic [15:0]         sw = 16'hA5C3;
    logic                fc = 1;
    logic                oa = 1;
    int                  n_mismatch = 0;
    int                  n_compared = 0;
    scwd_pkg::scwd_req_t req;
    scwd_pkg::scwd_rsp_t rsp;
    scwd_pkg::scwd_cmd_t cmd;
    logic                ack;
    logic [15:0]         cw;
    logic [15:0]         pf;
    logic [15:0]         q;
    logic                e;
    logic                ok;
    scwd_client client (.clk(clk), .rsp(rsp), .req(req));
    scwd_decoder dut (
        .clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .drive_status_word(sw),
        .fault_cond_clear(fc), .other_acks_done(oa), .cmd(cmd), .fault_ack_pulse(ack),
        .drive_control_word(cw), .fieldbus_profile_select(pf));
    initial forever #4 clk = ~clk;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic acc(input logic w, input scwd_pkg::scwd_obj_t o, input logic [15:0] a,
            input logic [15:0] d);
        client.xfer(w, o, a, d, q, e, ok);
        if (!ok) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    function automatic scwd_pkg::scwd_cmd_t exp_cmd(input logic [15:0] w);
        return '{w[1:0], !w[3], !w[4], !w[5], w[6], !w[6], w[8], w[9]};
    endfunction
    // write word, count pulses, compare commands of word x
    task automatic apply(input logic [15:0] w, input logic [15:0] x, input int np);
        int n = 0;
        acc(1, scwd_pkg::SCWD_OBJ_HOLDING, 16'h0002, w);
        repeat (4) begin
            #1;
            n += (ack === 1'b1);
            @(posedge clk);
        end
        #1;
        `CHK("cmd", exp_cmd(x), cmd)
        `CHK("pulses", np, n)
    endtask
    task automatic t_reset();
        `CHK("reset cmd", exp_cmd(16'h0000), cmd)
        `CHK("reset word", 16'h0000, cw)
    endtask
    task automatic t_decode();
        // bit 2 always zero
        logic [15:0] tbl [9] = '{16'h0478, 16'h0479, 16'h047A, 16'h047B, 16'h0400,
            16'h0778, 16'h0458, 16'h0468, 16'h0470};
        foreach (tbl[i]) apply(tbl[i], tbl[i], 0);
    endtask
    task automatic t_coil();
        acc(1, scwd_pkg::SCWD_OBJ_COIL, 16'h0008, 16'h0001);
        acc(0, scwd_pkg::SCWD_OBJ_COIL, 16'h0008, 16'h0000);
        `CHK("coil", 1'b1, q[0])
        `CHK("coil word", 16'h0570, cw)
        acc(1, scwd_pkg::SCWD_OBJ_COIL, 16'h0010, 16'h0001);
        `CHK("coil range", 1'b1, e)
    endtask
    task automatic t_ack();
        apply(16'h0478, 16'h0478, 0);
        apply(16'h04F8, 16'h04F8, 1);
        apply(16'h04F8, 16'h04F8, 0);
        apply(16'h0030, 16'h04F8, 0);
        apply(16'h0478, 16'h0478, 0);
        @(posedge clk) fc <= 0;
        apply(16'h04F8, 16'h04F8, 0);
        apply(16'h0478, 16'h0478, 0);
        @(posedge clk) fc <= 1;
        @(posedge clk) oa <= 0;
        apply(16'h04F8, 16'h04F8, 0);
        @(posedge clk) oa <= 1;
    endtask
    task automatic t_regs();
        acc(1, scwd_pkg::SCWD_OBJ_HOLDING, 16'h0001, 16'h1234);
        acc(0, scwd_pkg::SCWD_OBJ_HOLDING, 16'h0001, 16'h0000);
        `CHK("profile", 16'h1234, q)
        acc(1, scwd_pkg::SCWD_OBJ_INPUT, 16'h0000, 16'h5555);
        `CHK("input write", 1'b1, e)
        acc(0, scwd_pkg::SCWD_OBJ_INPUT, 16'h0000, 16'h0000);
        `CHK("status", 16'hA5C3, q)
        acc(0, scwd_pkg::SCWD_OBJ_HOLDING, 16'h0007, 16'h0000);
        `CHK("unmapped", 1'b1, e)
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_decode();
        t_coil();
        t_ack();
        t_regs();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
